// ### hw/tape_punch_pkg.sv
package tape_punch_pkg;

  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned CYCLE_US          = 8330;
  localparam int unsigned CYCLE_CLKS        = CYCLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DATA_HOLD_NS      = 2000;
  localparam int unsigned DATA_HOLD_CLKS    = (DATA_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FEED_PERIOD_US    = 8330;
  localparam int unsigned TRACKS            = 8;

  localparam logic [31:0] ADDR_CTRL         = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS       = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQ_STATUS   = 32'h0000_0008;
  localparam logic [31:0] ADDR_IRQ_MASK     = 32'h0000_000C;
  localparam logic [31:0] ADDR_LAST_ROW     = 32'h0000_0010;
  localparam logic [31:0] ADDR_ROW_COUNT    = 32'h0000_0014;

  localparam int unsigned CTRL_POL_BIT      = 0;
  localparam int unsigned CTRL_FAULT_BIT    = 1;

  localparam int unsigned ST_READY_BIT      = 0;
  localparam int unsigned ST_BUSY_BIT       = 1;
  localparam int unsigned ST_LOCK_BIT       = 2;
  localparam int unsigned ST_FAULT_BIT      = 3;
  localparam int unsigned ST_DIR_BIT        = 4;

  localparam int unsigned IRQ_DONE_BIT      = 0;
  localparam int unsigned IRQ_LOCK_BIT      = 1;
  localparam int unsigned IRQ_IGNORED_BIT   = 2;
  localparam int unsigned IRQ_W             = 3;

  localparam logic [1:0]  CTRL_RESET        = 2'h0;
  localparam logic [IRQ_W-1:0] MASK_RESET   = 3'h0;

  typedef struct packed {
    logic                forward;
    logic [TRACKS-1:0]   holes;
  } punch_row_t;

  typedef enum logic [1:0] {
    PS_IDLE   = 2'b00,
    PS_PUNCH  = 2'b01,
    PS_FEED   = 2'b10,
    PS_LOCKED = 2'b11
  } punch_state_t;

endpackage

// ### hw/punch_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module punch_cycle_timer
  import tape_punch_pkg::*;
#(
  parameter int unsigned CYCLE = CYCLE_CLKS
)
(
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  localparam int unsigned CW = $clog2(CYCLE + 1);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic          done_r;

  assign count_nxt = start_i ? CW'(CYCLE) : (count_r != '0 ? count_r - CW'(1) : count_r);
  assign busy_o    = (count_r != '0);
  assign done_o    = done_r;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      count_r <= '0;
      done_r  <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      done_r  <= (count_r == CW'(1)) && !start_i;
    end
  end

endmodule // punch_cycle_timer
`default_nettype wire

// ### hw/tape_punch_command_port.sv
// Functional notes
// [RULE1] Host keeps punch strobe inactive while operator feeds blank tape manually.
// [RULE2] Active-high setting: manual feed only advances while strobe input is low.
// [RULE3] Manual switch with strobe true locks punching until power is cycled.
// [RULE4] Each active track bit at a true strobe punches that track's hole.
// [RULE5] Host holds track data valid from strobe until two microseconds after.
// [RULE6] Direction active moves tape forward, inactive moves it in reverse.
// [RULE7] Track data polarity follows the input polarity select line.
// [RULE8] Strobe edge advances and punches one row; ignored when not ready or faulted.
// [RULE9] Ready drops within 1 us of strobe, stays low 8.33 ms and during fault.
// [RULE10] One polarity select line governs both strobe and track data.
// [RULE11] Track data captured on strobe's true edge and held through the cycle.
`timescale 1ns/1ps
`default_nettype none
module tape_punch_command_port
  import tape_punch_pkg::*;
#(
  parameter int unsigned CYCLE = CYCLE_CLKS
)
(
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  input  wire logic [TRACKS-1:0] track_data_i,
  input  wire logic              direction_i,
  input  wire logic              punch_strobe_in_i,
  input  wire logic              input_polarity_select_i,
  input  wire logic              manual_advance_switch_i,
  input  wire logic              tape_fault_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [31:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic                   perforator_ready_out_o,
  output logic                   supply_fault_out_o,
  output logic                   punch_fire_o,
  output logic                   tape_advance_o,
  output logic                   tape_forward_o,
  output logic [TRACKS-1:0]      punch_holes_o,
  output logic                   irq_o
);

  punch_state_t        state_r;
  punch_state_t        state_nxt;
  logic                strobe_prev_r;
  logic                switch_prev_r;
  punch_row_t          row_r;
  logic                fire_r;
  logic                advance_r;
  logic [1:0]          ctrl_r;
  logic [IRQ_W-1:0]    irq_status_r;
  logic [IRQ_W-1:0]    irq_mask_r;
  logic [31:0]         row_count_r;
  logic [31:0]         prdata_r;

  logic                polarity_high;
  logic                strobe_true;
  logic [TRACKS-1:0]   data_true;
  logic                strobe_edge;
  logic                switch_edge;
  logic                fault;
  logic                timer_busy;
  logic                timer_done;
  logic                timer_start;
  logic                accept;
  logic                ignored;
  logic                lock_evt;
  logic                feed_start;
  logic                apb_wr;
  logic                apb_rd;
  logic                addr_hit;
  logic [IRQ_W-1:0]    irq_set;
  logic [IRQ_W-1:0]    irq_clr;
  logic [31:0]         status_word;
  logic [31:0]         rd_mux;
  logic                in_idle;
  logic                in_locked;
  logic                hit_ctrl;
  logic                hit_status;
  logic                hit_irq_status;
  logic                hit_irq_mask;
  logic                hit_last_row;
  logic                hit_row_count;
  logic                wr_ctrl;
  logic                wr_irq_mask;
  logic                row_load;
  punch_row_t          row_nxt;
  logic [31:0]         row_count_nxt;
  logic [1:0]          ctrl_nxt;
  logic [IRQ_W-1:0]    irq_mask_nxt;
  logic [IRQ_W-1:0]    irq_status_nxt;
  logic [31:0]         prdata_nxt;

  // Software may invert the pin's convention by setting the register polarity bit
  assign polarity_high = input_polarity_select_i ^ ctrl_r[CTRL_POL_BIT];
  assign strobe_true   = polarity_high ? punch_strobe_in_i : !punch_strobe_in_i; // [RULE10]
  assign fault         = tape_fault_i | ctrl_r[CTRL_FAULT_BIT];
  assign strobe_edge   = strobe_true && !strobe_prev_r;
  assign switch_edge   = manual_advance_switch_i && !switch_prev_r;
  assign in_idle       = (state_r == PS_IDLE);
  assign in_locked     = (state_r == PS_LOCKED);

  // Same convention as the strobe, so one select line flips both together
  for (genvar t = 0; t < TRACKS; t++)
  begin : g_track
    assign data_true[t] = polarity_high ? track_data_i[t] : !track_data_i[t]; // [RULE7] [RULE10]
  end

  // Lock has priority: the switch with a true strobe wedges the logic
  assign lock_evt    = switch_edge && strobe_true && !in_locked;         // [RULE3]
  // Feed needs the strobe held false, which in active-high means the pin is low
  assign feed_start  = switch_edge && !strobe_true && in_idle && !fault; // [RULE2] [RULE1]
  assign accept      = strobe_edge && in_idle && !fault && !lock_evt;    // [RULE8]
  assign ignored     = strobe_edge && !accept && !lock_evt;              // [RULE8]
  assign timer_start = accept || feed_start;
  assign row_load    = accept || feed_start;

  punch_cycle_timer #(
    .CYCLE (CYCLE)
  ) u_timer (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (timer_start),
    .busy_o    (timer_busy),
    .done_o    (timer_done)
  );

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PS_IDLE:
      begin
        if (lock_evt)
          state_nxt = PS_LOCKED;
        else if (accept)
          state_nxt = PS_PUNCH;
        else if (feed_start)
          state_nxt = PS_FEED;
      end
      PS_PUNCH, PS_FEED:
      begin
        if (lock_evt)
          state_nxt = PS_LOCKED;
        else if (timer_done)
          state_nxt = PS_IDLE;
      end
      PS_LOCKED:
        state_nxt = PS_LOCKED; // [RULE3] Only reset (power cycle) leaves
    endcase
  end

  // Ready is combinational so it falls in the strobe's own cycle, well within 1 us
  assign perforator_ready_out_o = in_idle && !timer_busy && !fault && !strobe_edge; // [RULE9]
  assign supply_fault_out_o     = fault;
  assign punch_fire_o           = fire_r;
  assign tape_advance_o         = advance_r;
  assign tape_forward_o         = row_r.forward;
  assign punch_holes_o          = row_r.holes;

  // A blank feed row always runs forward and punches no track
  assign row_nxt       = accept ? {direction_i, data_true} : {1'b1, {TRACKS{1'b0}}}; // [RULE4] [RULE6] [RULE11]
  assign row_count_nxt = accept ? row_count_r + 32'h0000_0001 : row_count_r;

  // History starts true so a strobe or switch held through reset is no edge
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strobe_prev_r <= 1'b1;
      switch_prev_r <= 1'b1;
    end
    else
    begin
      strobe_prev_r <= strobe_true;
      switch_prev_r <= manual_advance_switch_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_r <= PS_IDLE;
    else
      state_r <= state_nxt; // [RULE3]
  end

  // Pulses to the mechanism are registered so they carry no decode glitches
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fire_r    <= 1'b0;
      advance_r <= 1'b0;
    end
    else
    begin
      fire_r    <= accept; // [RULE8]
      advance_r <= timer_start;
    end
  end

  // Captured once per cycle, so the host may drop the data after its hold time
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      row_r <= '0;
    else if (row_load)
      row_r <= row_nxt; // [RULE11]
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      row_count_r <= '0;
    else
      row_count_r <= row_count_nxt;
  end

  // APB slave, zero wait states; read data is latched in the setup phase
  assign apb_wr         = psel_i && penable_i && pwrite_i;
  assign apb_rd         = psel_i && !penable_i && !pwrite_i;
  assign hit_ctrl       = (paddr_i == ADDR_CTRL);
  assign hit_status     = (paddr_i == ADDR_STATUS);
  assign hit_irq_status = (paddr_i == ADDR_IRQ_STATUS);
  assign hit_irq_mask   = (paddr_i == ADDR_IRQ_MASK);
  assign hit_last_row   = (paddr_i == ADDR_LAST_ROW);
  assign hit_row_count  = (paddr_i == ADDR_ROW_COUNT);
  assign addr_hit       = hit_ctrl || hit_status || hit_irq_status || hit_irq_mask || hit_last_row || hit_row_count;
  assign wr_ctrl        = apb_wr && hit_ctrl;
  assign wr_irq_mask    = apb_wr && hit_irq_mask;
  assign pready_o       = 1'b1;
  assign pslverr_o      = psel_i && penable_i && !addr_hit;
  assign prdata_o       = prdata_r;

  always_comb
  begin
    status_word               = 32'h0000_0000;
    status_word[ST_READY_BIT] = perforator_ready_out_o;
    status_word[ST_BUSY_BIT]  = !in_idle || timer_busy;
    status_word[ST_LOCK_BIT]  = in_locked;
    status_word[ST_FAULT_BIT] = fault;
    status_word[ST_DIR_BIT]   = row_r.forward;
  end

  assign rd_mux = hit_ctrl       ? {30'h0, ctrl_r} :
                  hit_status     ? status_word :
                  hit_irq_status ? {29'h0, irq_status_r} :
                  hit_irq_mask   ? {29'h0, irq_mask_r} :
                  hit_last_row   ? {23'h0, row_r} :
                  hit_row_count  ? row_count_r : 32'h0000_0000;

  always_comb
  begin
    irq_set                  = '0;
    irq_set[IRQ_DONE_BIT]    = timer_done;
    irq_set[IRQ_LOCK_BIT]    = lock_evt;
    irq_set[IRQ_IGNORED_BIT] = ignored;
  end

  assign irq_clr = (apb_wr && hit_irq_status) ? pwdata_i[IRQ_W-1:0] : '0;
  assign irq_o   = |(irq_status_r & irq_mask_r);

  // Set beats clear so an event in the clearing cycle survives
  for (genvar b = 0; b < IRQ_W; b++)
  begin : g_irq
    assign irq_status_nxt[b] = irq_set[b] || (irq_status_r[b] && !irq_clr[b]);
  end

  assign ctrl_nxt     = wr_ctrl ? pwdata_i[1:0] : ctrl_r;
  assign irq_mask_nxt = wr_irq_mask ? pwdata_i[IRQ_W-1:0] : irq_mask_r;
  assign prdata_nxt   = apb_rd ? rd_mux : prdata_r;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_r     <= CTRL_RESET;
      irq_mask_r <= MASK_RESET;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq_status_r <= '0;
    else
      irq_status_r <= irq_status_nxt;
  end

  // Read data only moves in a read setup phase, so it stands through the access phase
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prdata_r <= '0;
    else
      prdata_r <= prdata_nxt;
  end

endmodule // tape_punch_command_port
`default_nettype wire

// ### verif/tape_punch_host.sv
`timescale 1ns/1ps
`default_nettype none
module punch_host_model
  import tape_punch_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              pol_i,
  input  wire logic              go_i,
  input  wire logic [TRACKS-1:0] row_i,
  output logic                   strobe_o,
  output logic [TRACKS-1:0]      data_o
);
  logic              act_r = 1'b0;
  logic [TRACKS-1:0] hole_r = '0;
  int                n_r = 0;
  assign strobe_o = act_r ~^ pol_i;
  assign data_o   = hole_r ^ {TRACKS{!pol_i}};
  always @(posedge ref_clk_i)
  begin
    if (go_i && !act_r)
    begin
      act_r  <= 1'b1;
      hole_r <= row_i;
      n_r    <= 0;
    end
    else if (act_r)
    begin
      n_r <= n_r + 1;
      // Scrambled after the hold so a late sample shows up as wrong holes
      if (n_r == DATA_HOLD_CLKS)
      begin
        act_r  <= 1'b0;
        hole_r <= ~hole_r;
      end
    end
  end
endmodule // punch_host_model
`default_nettype wire

// ### verif/tape_punch_command_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tape_punch_props
  import tape_punch_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              resetn_i,
  input wire logic [TRACKS-1:0] track_data_i,
  input wire logic              punch_strobe_in_i,
  input wire logic              input_polarity_select_i,
  input wire logic              manual_advance_switch_i,
  input wire logic              perforator_ready_out_o,
  input wire logic              supply_fault_out_o,
  input wire logic              punch_fire_o,
  input wire logic              tape_advance_o,
  input wire logic [TRACKS-1:0] punch_holes_o
);
  // Strobe true level; only valid while the register polarity invert stays clear
  wire st = punch_strobe_in_i ~^ input_polarity_select_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_take;
    $rose(st) && $past(perforator_ready_out_o) && !supply_fault_out_o;
  endsequence
  property p_drop; s_take |-> !perforator_ready_out_o; endproperty
  a_drop: assert property (p_drop) else $error("ready stayed high at strobe");
  property p_fire; s_take |=> punch_fire_o && tape_advance_o; endproperty
  a_fire: assert property (p_fire) else $error("no punch after strobe");
  property p_holes;
    s_take |=> punch_holes_o == ($past(track_data_i) ^ {TRACKS{!$past(input_polarity_select_i)}});
  endproperty
  a_holes: assert property (p_holes) else $error("holes differ from data");
  property p_busy; s_take |=> !perforator_ready_out_o [*8]; endproperty
  a_busy: assert property (p_busy) else $error("ready back too soon");
  property p_fault; supply_fault_out_o |-> !perforator_ready_out_o; endproperty
  a_fault: assert property (p_fault) else $error("ready during fault");
  property p_cause; punch_fire_o |-> $past(st && !supply_fault_out_o) && !$past(st, 2); endproperty
  a_cause: assert property (p_cause) else $error("punch without strobe edge");
  property p_lock; $rose(manual_advance_switch_i) && st |=> !perforator_ready_out_o [*8]; endproperty
  a_lock: assert property (p_lock) else $error("not locked");
  property p_feed; tape_advance_o && !punch_fire_o |-> $past(!st) && punch_holes_o == '0; endproperty
  a_feed: assert property (p_feed) else $error("feed with strobe true");
  c_take: cover property (s_take);
  c_lock: cover property ($rose(manual_advance_switch_i) && st);
  c_feed: cover property (tape_advance_o && !punch_fire_o);
endmodule // tape_punch_props
bind tape_punch_command_port tape_punch_props u_props (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .track_data_i(track_data_i), .punch_strobe_in_i(punch_strobe_in_i),
  .input_polarity_select_i(input_polarity_select_i), .manual_advance_switch_i(manual_advance_switch_i),
  .perforator_ready_out_o(perforator_ready_out_o), .supply_fault_out_o(supply_fault_out_o),
  .punch_fire_o(punch_fire_o), .tape_advance_o(tape_advance_o), .punch_holes_o(punch_holes_o));
`default_nettype wire

// ### verif/tape_punch_command_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tape_punch_command_port_bench;
  import tape_punch_pkg::*;
  logic        clk = 0, rst_n = 0, dir = 0, pol = 1, sw = 0, flt = 0, go = 0, psel = 0, pen = 0, pw = 0;
  logic [31:0] pa = 0, pd = 0, rd, prd;
  logic [7:0]  row = 0, td, holes;
  logic        st, perforator_ready_out, perr, serr, rdy, sfo, fire, adv, fwd, irq;
  int          n_errors = 0, checked = 0, fires = 0, advs = 0, f, a;
  initial forever #50 clk = ~clk;
  always @(posedge clk)
  begin
    fires += (fire === 1'b1);
    advs  += (adv === 1'b1);
  end
  tape_punch_command_port #(.CYCLE(40)) DUT (.ref_clk_i(clk), .resetn_i(rst_n), .track_data_i(td),
    .direction_i(dir), .punch_strobe_in_i(st), .input_polarity_select_i(pol), .manual_advance_switch_i(sw),
    .tape_fault_i(flt), .psel_i(psel), .penable_i(pen), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pd),
    .prdata_o(prd), .pready_o(perforator_ready_out), .pslverr_o(serr), .perforator_ready_out_o(rdy), .supply_fault_out_o(sfo),
    .punch_fire_o(fire), .tape_advance_o(adv), .tape_forward_o(fwd), .punch_holes_o(holes), .irq_o(irq));
  punch_host_model host (.ref_clk_i(clk), .pol_i(pol), .go_i(go), .row_i(row), .strobe_o(st), .data_o(td));
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g, input string n);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pw <= w; pa <= ad; pd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (perforator_ready_out !== 1'b1);
    rd = prd;
    perr = serr;
    psel <= 0; pen <= 0;
  endtask
  task wait_rdy;
    for (int i = 0; i < 200 && rdy !== 1'b1; i++) @(posedge clk);
  endtask
  task strobe;
    go <= 1; cyc(1); go <= 0;
  endtask
  task t_regs;
    apb(0, ADDR_CTRL, 0); chk(CTRL_RESET, rd, "ctrl");
    apb(0, ADDR_IRQ_MASK, 0); chk(MASK_RESET, rd, "mask");
    apb(1, 32'h0000_0020, 32'hFFFF_FFFF); chk(1, perr, "slverr");
    chk(1, perforator_ready_out, "pready");
  endtask
  task t_punch(input logic p, input logic d, input logic [7:0] r);
    pol <= p; dir <= d; row <= r; cyc(2); f = fires;
    strobe(); cyc(2);
    chk(0, rdy, "ready in cycle");
    wait_rdy();
    chk(f + 1, fires, "rows");
    chk(r, holes, "holes");
    chk(d, fwd, "forward");
    cyc(5);
  endtask
  task t_irq;
    apb(0, ADDR_IRQ_STATUS, 0); chk(1, rd[IRQ_DONE_BIT], "done bit");
    chk(0, irq, "irq masked");
    apb(1, ADDR_IRQ_MASK, 1); cyc(1); chk(1, irq, "irq");
    apb(0, ADDR_ROW_COUNT, 0); chk(2, rd, "row count");
    apb(0, ADDR_LAST_ROW, 0); chk(32'h0000_003C, rd, "last row");
    apb(1, ADDR_IRQ_STATUS, 7); apb(0, ADDR_IRQ_STATUS, 0); chk(0, rd, "w1c");
    chk(0, irq, "irq clear");
  endtask
  task t_busy;
    f = fires; strobe(); cyc(24); strobe(); wait_rdy();
    chk(f + 1, fires, "busy strobe");
    apb(0, ADDR_IRQ_STATUS, 0); chk(1, rd[IRQ_IGNORED_BIT], "ignored bit");
    apb(1, ADDR_IRQ_STATUS, 7); cyc(25);
  endtask
  task t_fault;
    flt <= 1; cyc(2); f = fires;
    chk(1, sfo, "fault"); chk(0, rdy, "fault ready");
    strobe(); cyc(25);
    chk(f, fires, "fault strobe");
    flt <= 0; cyc(2); chk(1, rdy, "fault gone");
    apb(1, ADDR_CTRL, 1 << CTRL_FAULT_BIT); cyc(1);
    chk(1, sfo, "forced fault"); chk(0, rdy, "forced ready");
    apb(1, ADDR_CTRL, 0); cyc(1); chk(1, rdy, "forced gone");
  endtask
  task t_feed;
    pol <= 1; cyc(2); a = advs; f = fires;
    sw <= 1; cyc(1); sw <= 0; cyc(3);
    chk(a + 1, advs, "feed"); chk(0, holes, "feed holes"); chk(f, fires, "feed punch");
    wait_rdy(); cyc(5);
  endtask
  task t_lock;
    strobe(); cyc(3); sw <= 1; cyc(1); sw <= 0; cyc(100);
    chk(0, rdy, "locked");
    apb(0, ADDR_STATUS, 0); chk(1, rd[ST_LOCK_BIT], "lock bit");
    rst_n <= 0; cyc(2); rst_n <= 1; cyc(2);
    chk(1, rdy, "power cycle");
  endtask
  initial
  begin
    cyc(4); rst_n <= 1; cyc(1);
    t_regs(); t_punch(1, 1, 8'hA5); t_punch(0, 0, 8'h3C); t_irq();
    t_busy(); t_fault(); t_feed(); t_lock();
    print_verdict();
  end
  initial
  begin
    #500_000;
    n_errors++;
    print_verdict();
  end
endmodule // tape_punch_command_port_bench
`default_nettype wire
